// ===== core/string_unit_pkg.sv
package string_unit_pkg;

	// Widths of the datapath.
	localparam int ADDR_W = 32;
	localparam int LEN_W = 16;

	// Operation codes.
	localparam logic [7:0] OP_MERGE = 8'h00EA;
	localparam logic [7:0] OP_COMPARE = 8'h00FD;

	// Modifier bits that suppress index updates.
	localparam int MOD_HOLD_A_BIT = 5;
	localparam int MOD_HOLD_B_BIT = 6;

	// Outcome bit positions in the data flag register.
	localparam int FLAG_EQ_BIT = 53;
	localparam int FLAG_GT_BIT = 54;
	localparam int FLAG_LT_BIT = 55;

	// Field termination kinds.
	localparam logic [1:0] LEN_EXPLICIT = 2'h0;
	localparam logic [1:0] LEN_DELIM8 = 2'h1;
	localparam logic [1:0] LEN_DELIM16 = 2'h2;

	// Fill bytes and masks.
	localparam logic [7:0] NULL_BYTE = 8'h0000;
	localparam logic [7:0] BLANK_RESET = 8'h0020;
	localparam logic [7:0] FULL_MASK = 8'h00FF;

	// Register offsets and fields.
	localparam logic [3:0] REG_CTRL = 4'h0000;
	localparam logic [3:0] REG_BLANK = 4'h0004;
	localparam logic [3:0] REG_STATUS = 4'h0008;
	localparam logic [3:0] REG_COUNT = 4'h000C;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_M_RA,
		ST_M_RB,
		ST_M_WR,
		ST_C_RA,
		ST_C_RB,
		ST_C_RM,
		ST_C_EV,
		ST_FIN
	} state_t;

endpackage

// ===== core/byte_ops.sv
`timescale 1ns/1ns
module byte_ops
(
	// Operand bytes.
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] cmp_mask,
	input wire logic [7:0] sel_mask,
	// Results.
	output logic [7:0] merged,
	output logic differ,
	output logic a_greater
);

	// Bits of a where the select mask is one, bits of b where it is zero.
	assign merged = (a & sel_mask) | (b & ~sel_mask);

	// Masked bytes compare as unsigned values; unmasked bits always match.
	wire logic [7:0] a_m = a & cmp_mask;
	wire logic [7:0] b_m = b & cmp_mask;
	assign differ = a_m != b_m;
	assign a_greater = a_m > b_m;

endmodule

// ===== core/delim_detect.sv
`timescale 1ns/1ns
module delim_detect
(
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Byte stream.
	input wire logic clear,
	input wire logic valid,
	input wire logic [7:0] byte_in,
	// Termination setup.
	input wire logic [1:0] mode,
	input wire logic [15:0] delim,
	// Result.
	output logic hit
);

	logic [7:0] prev_q;
	logic seen_q;

	// The previous byte is kept so a two-byte delimiter can span two reads.
	always_ff @(posedge clock)
	begin
		if (!nrst || clear)
		begin
			prev_q <= 8'h0000;
			seen_q <= 1'b0;
		end
		else if (valid)
		begin
			prev_q <= byte_in;
			seen_q <= 1'b1;
		end
	end

	wire logic hit8 = mode == string_unit_pkg::LEN_DELIM8 && byte_in == delim[7:0];
	wire logic hit16 = mode == string_unit_pkg::LEN_DELIM16 && seen_q && {prev_q, byte_in} == delim;
	assign hit = valid && (hit8 || hit16);

endmodule

// ===== core/masked_byte_string_unit.sv
`timescale 1ns/1ns
module masked_byte_string_unit
(
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Instruction issue.
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] modifier,
	input wire logic [1:0] len_type,
	input wire logic mask_zero,
	input wire logic [31:0] base_a,
	input wire logic [31:0] idx_a,
	input wire logic [15:0] len_a,
	input wire logic [31:0] base_b,
	input wire logic [31:0] idx_b,
	input wire logic [15:0] len_b,
	input wire logic [31:0] base_c,
	input wire logic [31:0] idx_c,
	input wire logic [15:0] len_c,
	// Completion.
	output logic busy,
	output logic done,
	output logic [31:0] idx_a_new,
	output logic idx_a_we,
	output logic [31:0] idx_b_new,
	output logic idx_b_we,
	output logic [63:0] data_flag_register,
	output logic flag_we,
	// Memory read port, data one cycle after the strobe.
	output logic mem_rd,
	output logic [31:0] mem_rd_addr,
	input wire logic [7:0] mem_rd_data,
	// Memory write port.
	output logic mem_wr,
	output logic [31:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	string_unit_pkg::state_t state_q, state_d;

	// Latched instruction.
	logic [7:0] mod_q;
	logic [1:0] ltype_q;
	logic mzero_q;
	logic [31:0] base_a_q, idx_a_q, base_b_q, idx_b_q, base_c_q, idx_c_q;
	logic [15:0] len_a_q, len_b_q, len_c_q;

	// Progress and captured bytes.
	logic [15:0] n_q, n_d;
	logic [7:0] a_q, b_q;
	logic a_hit_q, b_hit_q;
	logic [15:0] a_cnt_q, b_cnt_q;
	logic [15:0] inc_a_q, inc_b_q;
	logic [2:0] flag_q, res_q;
	logic res_cmp_q;

	// Outputs held in flip-flops.
	logic done_q, idx_a_we_q, idx_b_we_q, flag_we_q;
	logic [31:0] idx_a_new_q, idx_b_new_q;
	logic mem_rd_q, mem_wr_q;
	logic [31:0] mem_rd_addr_q, mem_wr_addr_q;
	logic [7:0] mem_wr_data_q;

	// Software registers.
	logic enable_q, illegal_q;
	logic [7:0] blank_q;
	logic [15:0] count_q;
	logic [31:0] reg_rdata_q;

	// Byte position as a full-width address offset.
	function automatic logic [31:0] at(input logic [31:0] base, input logic [31:0] idx,
		input logic [15:0] pos);
		at = base + idx + {16'h0000, pos};
	endfunction

	// Start decode.
	wire logic is_merge = opcode == string_unit_pkg::OP_MERGE;
	wire logic is_cmp = opcode == string_unit_pkg::OP_COMPARE;
	wire logic take = start && state_q == string_unit_pkg::ST_IDLE && enable_q;
	wire logic [15:0] n_inc = n_q + 16'h0001;

	// A field is over by count or by a delimiter already seen.
	wire logic explicit_len = ltype_q == string_unit_pkg::LEN_EXPLICIT;
	wire logic a_over = explicit_len ? n_q >= len_a_q : a_hit_q;
	wire logic b_over = explicit_len ? n_q >= len_b_q : b_hit_q;
	// The first read leaves in the take cycle, before the operands are latched.
	wire logic idle = state_q == string_unit_pkg::ST_IDLE;
	wire logic [15:0] len_a_now = idle ? len_a : len_a_q;
	wire logic [31:0] base_a_now = idle ? base_a : base_a_q;
	wire logic [31:0] idx_a_now = idle ? idx_a : idx_a_q;
	wire logic a_live_m = n_d < len_a_now;
	wire logic b_live_m = n_d < len_b_q;
	wire logic b_live_q = n_q < len_b_q;
	// End of the first source at the position about to be read.
	wire logic a_end_d = explicit_len ? n_d >= len_a_q : a_hit_q;

	// Delimiter detection on each source stream.
	wire logic a_byte_valid = state_q == string_unit_pkg::ST_C_RB && !a_over;
	wire logic b_byte_valid = state_q == string_unit_pkg::ST_C_RM && !b_over;
	logic a_hit, b_hit;

	delim_detect det_a
	(
		.clock(clock),
		.nrst(nrst),
		.clear(take),
		.valid(a_byte_valid),
		.byte_in(mem_rd_data),
		.mode(ltype_q),
		.delim(len_a_q),
		.hit(a_hit)
	);

	delim_detect det_b
	(
		.clock(clock),
		.nrst(nrst),
		.clear(take),
		.valid(b_byte_valid),
		.byte_in(mem_rd_data),
		.mode(ltype_q),
		.delim(len_b_q),
		.hit(b_hit)
	);

	// Byte operations; an absent mask field means every bit is compared.
	wire logic [7:0] cmp_mask = mzero_q ? string_unit_pkg::FULL_MASK : mem_rd_data;
	wire logic [7:0] b_merge = b_live_q ? mem_rd_data : string_unit_pkg::NULL_BYTE;
	logic [7:0] merged;
	logic differ, a_greater;

	byte_ops ops
	(
		.a(a_q),
		.b(state_q == string_unit_pkg::ST_M_WR ? b_merge : b_q),
		.cmp_mask(cmp_mask),
		.sel_mask(mod_q),
		.merged(merged),
		.differ(differ),
		.a_greater(a_greater)
	);

	// Full increment: the count for explicit fields, else the span through the delimiter.
	wire logic [15:0] full_a = explicit_len ? len_a_q : a_cnt_q;
	wire logic [15:0] full_b = explicit_len ? len_b_q : b_cnt_q;

	// Next state.
	always_comb
	begin
		state_d = state_q;
		n_d = n_q;
		case (state_q)
			string_unit_pkg::ST_IDLE:
			begin
				n_d = 16'h0000;
				if (take && is_merge)
					state_d = len_c == 16'h0000 ? string_unit_pkg::ST_FIN
						: string_unit_pkg::ST_M_RA;
				else if (take && is_cmp)
					state_d = string_unit_pkg::ST_C_RA;
			end
			string_unit_pkg::ST_M_RA:
				state_d = string_unit_pkg::ST_M_RB;
			string_unit_pkg::ST_M_RB:
				state_d = string_unit_pkg::ST_M_WR;
			string_unit_pkg::ST_M_WR:
			begin
				n_d = n_inc;
				state_d = n_inc == len_c_q ? string_unit_pkg::ST_FIN
					: string_unit_pkg::ST_M_RA;
			end
			string_unit_pkg::ST_C_RA:
				state_d = a_over && b_over ? string_unit_pkg::ST_FIN
					: string_unit_pkg::ST_C_RB;
			string_unit_pkg::ST_C_RB:
				state_d = string_unit_pkg::ST_C_RM;
			string_unit_pkg::ST_C_RM:
				state_d = string_unit_pkg::ST_C_EV;
			string_unit_pkg::ST_C_EV:
			begin
				if (differ)
					state_d = string_unit_pkg::ST_FIN;
				else
				begin
					n_d = n_inc;
					state_d = string_unit_pkg::ST_C_RA;
				end
			end
			string_unit_pkg::ST_FIN:
				state_d = string_unit_pkg::ST_IDLE;
			default:
				state_d = string_unit_pkg::ST_IDLE;
		endcase
	end

	// Read strobes stand in the state that names them; the data is taken one state later.
	wire logic rd_a_m = state_d == string_unit_pkg::ST_M_RA && a_live_m;
	wire logic rd_b_m = state_d == string_unit_pkg::ST_M_RB && b_live_m;
	wire logic rd_a_c = state_d == string_unit_pkg::ST_C_RA && (idle || !a_end_d);
	wire logic rd_b_c = state_d == string_unit_pkg::ST_C_RB && !b_over;
	wire logic rd_m_c = state_d == string_unit_pkg::ST_C_RM && !mzero_q;
	wire logic rd_a_any = rd_a_m || rd_a_c;
	wire logic rd_b_any = rd_b_m || rd_b_c;
	wire logic [31:0] rd_addr_d = rd_a_any ? at(base_a_now, idx_a_now, n_d)
		: rd_b_any ? at(base_b_q, idx_b_q, n_d) : at(base_c_q, idx_c_q, n_d);

	// State, counter and latched instruction.
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			state_q <= string_unit_pkg::ST_IDLE;
			n_q <= 16'h0000;
		end
		else
		begin
			state_q <= state_d;
			n_q <= n_d;
		end
	end

	always_ff @(posedge clock)
	begin
		if (take)
		begin
			mod_q <= modifier;
			ltype_q <= len_type;
			mzero_q <= mask_zero;
			base_a_q <= base_a;
			idx_a_q <= idx_a;
			len_a_q <= len_a;
			base_b_q <= base_b;
			idx_b_q <= idx_b;
			len_b_q <= len_b;
			base_c_q <= base_c;
			idx_c_q <= idx_c;
			len_c_q <= len_c;
			res_cmp_q <= is_cmp;
		end
	end

	// Source bytes; ended sources and the byte that completes a delimiter read as padding.
	always_ff @(posedge clock)
	begin
		if (state_q == string_unit_pkg::ST_M_RB)
			a_q <= a_live_m ? mem_rd_data : string_unit_pkg::NULL_BYTE;
		else if (state_q == string_unit_pkg::ST_C_RB)
			a_q <= a_over || a_hit ? blank_q : mem_rd_data;
		if (state_q == string_unit_pkg::ST_C_RM)
			b_q <= b_over || b_hit ? blank_q : mem_rd_data;
	end

	// Delimiter positions; one source ending does not stop the compare.
	always_ff @(posedge clock)
	begin
		if (!nrst || take)
		begin
			a_hit_q <= 1'b0;
			b_hit_q <= 1'b0;
			a_cnt_q <= 16'h0000;
			b_cnt_q <= 16'h0000;
		end
		else
		begin
			if (a_hit)
			begin
				a_hit_q <= 1'b1;
				a_cnt_q <= n_inc;
			end
			if (b_hit)
			begin
				b_hit_q <= 1'b1;
				b_cnt_q <= n_inc;
			end
		end
	end

	// Outcome: inequality counts compares before it, exhaustion uses full lengths.
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			res_q <= 3'h0;
			inc_a_q <= 16'h0000;
			inc_b_q <= 16'h0000;
		end
		else if (state_q == string_unit_pkg::ST_C_EV && differ)
		begin
			res_q <= a_greater ? 3'h2 : 3'h4;
			inc_a_q <= n_q;
			inc_b_q <= n_q;
		end
		else if (state_q == string_unit_pkg::ST_C_RA && a_over && b_over)
		begin
			res_q <= 3'h1;
			inc_a_q <= full_a;
			inc_b_q <= full_b;
		end
	end

	// Completion pulses; merge never writes indexes or flags.
	wire logic fin = state_q == string_unit_pkg::ST_FIN;
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			done_q <= 1'b0;
			idx_a_we_q <= 1'b0;
			idx_b_we_q <= 1'b0;
			flag_we_q <= 1'b0;
			flag_q <= 3'h0;
			idx_a_new_q <= 32'h0000_0000;
			idx_b_new_q <= 32'h0000_0000;
			count_q <= 16'h0000;
		end
		else
		begin
			done_q <= fin;
			idx_a_we_q <= fin && res_cmp_q && !mod_q[string_unit_pkg::MOD_HOLD_A_BIT];
			idx_b_we_q <= fin && res_cmp_q && !mod_q[string_unit_pkg::MOD_HOLD_B_BIT];
			flag_we_q <= fin && res_cmp_q;
			if (fin)
			begin
				idx_a_new_q <= idx_a_q + {16'h0000, inc_a_q};
				idx_b_new_q <= idx_b_q + {16'h0000, inc_b_q};
				count_q <= n_q;
				if (res_cmp_q)
					flag_q <= res_q;
			end
		end
	end

	// Memory ports are registered so addresses never glitch.
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_rd_addr_q <= 32'h0000_0000;
			mem_wr_addr_q <= 32'h0000_0000;
			mem_wr_data_q <= 8'h0000;
		end
		else
		begin
			mem_rd_q <= rd_a_any || rd_b_any || rd_m_c;
			mem_rd_addr_q <= rd_addr_d;
			mem_wr_q <= state_q == string_unit_pkg::ST_M_WR;
			if (state_q == string_unit_pkg::ST_M_WR)
			begin
				mem_wr_addr_q <= at(base_c_q, idx_c_q, n_q);
				mem_wr_data_q <= merged;
			end
		end
	end

	// Register writes; the blank byte and the enable steer the block.
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			enable_q <= string_unit_pkg::CTRL_ENABLE_RESET;
			blank_q <= string_unit_pkg::BLANK_RESET;
			illegal_q <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == string_unit_pkg::REG_CTRL)
				enable_q <= reg_wdata[string_unit_pkg::CTRL_ENABLE_BIT];
			if (reg_wr && reg_addr == string_unit_pkg::REG_BLANK)
				blank_q <= reg_wdata[7:0];
			if (take)
				illegal_q <= !is_merge && !is_cmp;
		end
	end

	// Register read decode; unmapped offsets read as zero.
	wire logic [31:0] status_word = {26'h0000_000, illegal_q, flag_q, 1'b0, busy};
	wire logic [31:0] rd_sel = reg_addr == string_unit_pkg::REG_CTRL ? {31'h0000_0000, enable_q}
		: reg_addr == string_unit_pkg::REG_BLANK ? {24'h00_0000, blank_q}
		: reg_addr == string_unit_pkg::REG_STATUS ? status_word
		: reg_addr == string_unit_pkg::REG_COUNT ? {16'h0000, count_q}
		: 32'h0000_0000;

	always_ff @(posedge clock)
	begin
		if (!nrst)
			reg_rdata_q <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata_q <= rd_sel;
	end

	// Output wiring.
	assign busy = state_q != string_unit_pkg::ST_IDLE;
	assign done = done_q;
	assign idx_a_new = idx_a_new_q;
	assign idx_a_we = idx_a_we_q;
	assign idx_b_new = idx_b_new_q;
	assign idx_b_we = idx_b_we_q;
	assign flag_we = flag_we_q;
	assign data_flag_register = 64'(flag_q) << string_unit_pkg::FLAG_EQ_BIT;
	assign mem_rd = mem_rd_q;
	assign mem_rd_addr = mem_rd_addr_q;
	assign mem_wr = mem_wr_q;
	assign mem_wr_addr = mem_wr_addr_q;
	assign mem_wr_data = mem_wr_data_q;
	assign reg_rdata = reg_rdata_q;

endmodule

// ===== tb/string_unit_chk.sv
`timescale 1ns/1ns
module string_unit_chk
(
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Issue.
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] modifier,
	input wire logic [1:0] len_type,
	input wire logic [31:0] idx_a,
	input wire logic [15:0] len_a,
	input wire logic [31:0] idx_b,
	input wire logic [15:0] len_c,
	// Completion and memory writes.
	input wire logic busy,
	input wire logic done,
	input wire logic [31:0] idx_a_new,
	input wire logic idx_a_we,
	input wire logic [31:0] idx_b_new,
	input wire logic idx_b_we,
	input wire logic [63:0] data_flag_register,
	input wire logic flag_we,
	input wire logic mem_wr
);
	logic [7:0] op_q;
	logic [7:0] mod_q;
	logic [1:0] lt_q;
	logic [31:0] ia_q, ib_q;
	logic [15:0] la_q, lc_q, wr_cnt_q;
	logic take, merge_end, cmp_end;

	// Ends are judged against the operands kept at the take, as issue lines may move.
	assign take = start && !busy;
	assign merge_end = done && op_q == string_unit_pkg::OP_MERGE;
	assign cmp_end = done && op_q == string_unit_pkg::OP_COMPARE;

	// Operands of the running operation and its count of result writes.
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			op_q <= 8'h00;
			wr_cnt_q <= 16'h0000;
		end
		else if (take)
		begin
			op_q <= opcode;
			mod_q <= modifier;
			lt_q <= len_type;
			ia_q <= idx_a;
			ib_q <= idx_b;
			la_q <= len_a;
			lc_q <= len_c;
			wr_cnt_q <= 16'h0000;
		end
		else if (mem_wr)
			wr_cnt_q <= wr_cnt_q + 16'h0001;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	flag_onehot_a: assert property (flag_we |-> $onehot(data_flag_register[55:53]))
		else $error("outcome flags not one-hot");
	flag_clean_a: assert property (flag_we |-> data_flag_register[52:0] == 53'h0
		&& data_flag_register[63:56] == 8'h00) else $error("stray flag bit set");
	merge_quiet_a: assert property (merge_end |-> !idx_a_we && !idx_b_we && !flag_we)
		else $error("merge touched an index or flag");
	merge_count_a: assert property (merge_end |-> wr_cnt_q == lc_q)
		else $error("merge wrote a wrong number of bytes");
	merge_stop_a: assert property (mem_wr && op_q == string_unit_pkg::OP_MERGE
		&& wr_cnt_q == lc_q - 16'h0001 |-> ##[1:2] done) else $error("merge ran on");
	hold_a_a: assert property (cmp_end && mod_q[string_unit_pkg::MOD_HOLD_A_BIT] |-> !idx_a_we)
		else $error("held first index updated");
	hold_b_a: assert property (cmp_end && mod_q[string_unit_pkg::MOD_HOLD_B_BIT] |-> !idx_b_we)
		else $error("held second index updated");
	same_step_a: assert property (cmp_end && !data_flag_register[53] && idx_a_we && idx_b_we
		|-> idx_a_new - ia_q == idx_b_new - ib_q) else $error("unequal index steps");
	full_step_a: assert property (cmp_end && lt_q == string_unit_pkg::LEN_EXPLICIT
		&& data_flag_register[53] && idx_a_we |-> idx_a_new == ia_q + {16'h0000, la_q})
		else $error("equal compare index step wrong");

	merge_seen_c: cover property (merge_end);
	equal_seen_c: cover property (cmp_end && data_flag_register[53]);
	greater_seen_c: cover property (cmp_end && data_flag_register[54]);
endmodule

bind masked_byte_string_unit string_unit_chk u_chk (.clock(clock), .nrst(nrst), .start(start),
	.opcode(opcode), .modifier(modifier), .len_type(len_type), .idx_a(idx_a), .len_a(len_a),
	.idx_b(idx_b), .len_c(len_c), .busy(busy), .done(done), .idx_a_new(idx_a_new),
	.idx_a_we(idx_a_we), .idx_b_new(idx_b_new), .idx_b_we(idx_b_we),
	.data_flag_register(data_flag_register), .flag_we(flag_we), .mem_wr(mem_wr));

// ===== tb/byte_memory.sv
`timescale 1ns/1ns
module byte_memory
(
	// Clock.
	input wire logic clock,
	// Read port.
	input wire logic rd,
	input wire logic [31:0] rd_addr,
	output logic [7:0] rd_data,
	// Write port.
	input wire logic wr,
	input wire logic [31:0] wr_addr,
	input wire logic [7:0] wr_data
);
	logic [7:0] mem [0:4095];
	logic [7:0] last_q = 8'h00;
	logic valid_q = 1'b0;

	// Data stands only in the cycle after the strobe; otherwise it shows the inverse.
	always @(posedge clock)
	begin
		valid_q <= rd;
		if (rd)
			last_q <= mem[rd_addr[11:0]];
		if (wr)
			mem[wr_addr[11:0]] <= wr_data;
	end
	assign rd_data = valid_q ? last_q : ~last_q;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic clock = 1'b0, nrst = 1'b0, start = 1'b0, mask_zero = 1'b0;
	logic [7:0] opcode = 8'h00, modifier = 8'h00;
	logic [1:0] len_type = 2'h0;
	logic [31:0] base_a = 32'h0000_0100, idx_a = 32'h0000_0010, base_b = 32'h0000_0200;
	logic [31:0] idx_b = 32'h0000_0010, base_c = 32'h0000_0300, idx_c = 32'h0000_0000;
	logic [15:0] len_a = 16'h0000, len_b = 16'h0000, len_c = 16'h0000;
	logic busy, done, idx_a_we, idx_b_we, flag_we, mem_rd, mem_wr, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] idx_a_new, idx_b_new, mem_rd_addr, mem_wr_addr, reg_rdata, rv;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [63:0] data_flag_register;
	logic [7:0] mem_rd_data, mem_wr_data, a, b;
	logic [3:0] reg_addr = 4'h0;
	int n_errors = 0, n_compared = 0, cycles = 0;

	masked_byte_string_unit u_masked_byte_string_unit (.clock(clock), .nrst(nrst), .start(start),
		.opcode(opcode), .modifier(modifier), .len_type(len_type), .mask_zero(mask_zero),
		.base_a(base_a), .idx_a(idx_a), .len_a(len_a), .base_b(base_b), .idx_b(idx_b),
		.len_b(len_b), .base_c(base_c), .idx_c(idx_c), .len_c(len_c), .busy(busy), .done(done),
		.idx_a_new(idx_a_new), .idx_a_we(idx_a_we), .idx_b_new(idx_b_new), .idx_b_we(idx_b_we),
		.data_flag_register(data_flag_register), .flag_we(flag_we), .mem_rd(mem_rd),
		.mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr(mem_wr),
		.mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	byte_memory u_byte_memory (.clock(clock), .rd(mem_rd), .rd_addr(mem_rd_addr),
		.rd_data(mem_rd_data), .wr(mem_wr), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data));

	// Clock, and a ceiling on cycles in case the unit never finishes.
	always #5 clock = ~clock;
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			summarize();
		end
	end

	task automatic summarize;
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		n_compared++;
		if (seen !== want)
		begin
			n_errors++;
			$display("FAIL %0t seen %h want %h", $time, seen, want);
		end
	endtask

	// Four bytes into memory, leftmost first.
	task automatic put4(input logic [11:0] ad, input logic [31:0] w);
		for (int i = 0; i < 4; i++)
			u_byte_memory.mem[ad + 12'(i)] = w[8 * (3 - i) +: 8];
	endtask

	task automatic reg_access(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
		@(posedge clock);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= ad;
		reg_wdata <= wd;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(negedge clock);
		rv = reg_rdata;
	endtask

	// Issue one operation and wait a bounded time for its done pulse.
	task automatic run(input logic [7:0] op, input logic [7:0] m, input logic [1:0] lt,
		input logic mz, input logic [15:0] la, input logic [15:0] lb, input logic [15:0] lc,
		input logic [31:0] cb);
		int n;
		@(posedge clock);
		opcode <= op;
		modifier <= m;
		len_type <= lt;
		mask_zero <= mz;
		len_a <= la;
		len_b <= lb;
		len_c <= lc;
		base_c <= cb;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		check(done, 1'b1);
	endtask

	task automatic cmp(input logic [7:0] m, input logic mz, input logic [1:0] lt,
		input logic [15:0] la, input logic [15:0] lb, input logic [31:0] wa,
		input logic [31:0] wb, input int fb, input logic [31:0] ia, input logic [31:0] ib);
		put4(12'h110, wa);
		put4(12'h210, wb);
		put4(12'h300, 32'hFF0F_FFFF);
		run(string_unit_pkg::OP_COMPARE, m, lt, mz, la, lb, 16'h0000, 32'h0000_0300);
		check(data_flag_register, 64'h1 << fb);
		check(idx_a_we, !m[5]);
		check(idx_b_we, !m[6]);
		if (!m[5])
			check(idx_a_new, 32'h0000_0010 + ia);
		if (!m[6])
			check(idx_b_new, 32'h0000_0010 + ib);
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		reg_access(1'b0, string_unit_pkg::REG_BLANK, 32'h0000_0000);
		check(rv, 32'h0000_0020);
		reg_access(1'b0, 4'h2, 32'h0000_0000);
		check(rv, 32'h0000_0000);
		reg_access(1'b1, string_unit_pkg::REG_BLANK, 32'h0000_005F);
		reg_access(1'b0, string_unit_pkg::REG_BLANK, 32'h0000_0000);
		check(rv, 32'h0000_005F);
		reg_access(1'b1, string_unit_pkg::REG_BLANK, 32'h0000_0020);
		// Merge under mask 0x0F, result longer than the sources and then as long as the shorter one.
		put4(12'h110, 32'h3132_AAAA);
		put4(12'h210, 32'hF0AA_AAAA);
		for (int k = 0; k < 2; k++)
		begin
			put4(12'h400, 32'hAAAA_AAAA);
			put4(12'h404, 32'hAAAA_AAAA);
			run(string_unit_pkg::OP_MERGE, 8'h0F, 2'h0, 1'b0, 16'h0002, 16'h0001,
				k ? 16'h0001 : 16'h0004, 32'h0000_0400);
			for (int i = 0; i < 5; i++)
			begin
				a = (i < 2) ? u_byte_memory.mem[12'h110 + 12'(i)] : string_unit_pkg::NULL_BYTE;
				b = (i < 1) ? u_byte_memory.mem[12'h210 + 12'(i)] : string_unit_pkg::NULL_BYTE;
				check(u_byte_memory.mem[12'h400 + 12'(i)], (i < (k ? 1 : 4)) ?
					((a & 8'h0F) | (b & ~8'h0F)) : 8'hAA);
			end
		end
		// Compares: padding, masking, holds, delimiters of both kinds.
		cmp(8'h00, 1'b1, 2'h0, 16'h0003, 16'h0002, 32'h4142_2099, 32'h4142_9999,
			string_unit_pkg::FLAG_EQ_BIT, 32'h0000_0003, 32'h0000_0002);
		cmp(8'h40, 1'b0, 2'h0, 16'h0003, 16'h0003, 32'h4152_8000, 32'h4132_0100,
			string_unit_pkg::FLAG_GT_BIT, 32'h0000_0002, 32'h0000_0000);
		cmp(8'h20, 1'b0, 2'h0, 16'h0003, 16'h0003, 32'h4152_0100, 32'h4132_8000,
			string_unit_pkg::FLAG_LT_BIT, 32'h0000_0000, 32'h0000_0002);
		cmp(8'h00, 1'b1, 2'h0, 16'h0003, 16'h0003, 32'h4152_0100, 32'h4132_8000,
			string_unit_pkg::FLAG_GT_BIT, 32'h0000_0001, 32'h0000_0001);
		reg_access(1'b0, string_unit_pkg::REG_STATUS, 32'h0000_0000);
		check(rv, 32'h0000_0008);
		reg_access(1'b0, string_unit_pkg::REG_COUNT, 32'h0000_0000);
		check(rv, 32'h0000_0001);
		cmp(8'h00, 1'b1, 2'h1, 16'h002E, 16'h002E, 32'h412E_5555, 32'h4120_202E,
			string_unit_pkg::FLAG_EQ_BIT, 32'h0000_0002, 32'h0000_0004);
		cmp(8'h00, 1'b1, 2'h2, 16'h2E2F, 16'h2E2F, 32'h412E_2F55, 32'h412E_2F77,
			string_unit_pkg::FLAG_EQ_BIT, 32'h0000_0003, 32'h0000_0003);
		summarize();
	end
endmodule
